// *** hdl/cch_pkg.sv ***
// Shared constants for the character channel handshake: widths, pulse timing, link bit layout.
// Assumes a single 20 MHz clock on both ends of the link.
package cch_pkg;
	localparam int          CHAR_W        = 6;             // Character width on the data lines
	localparam int          UNIT_W        = 6;             // Unit address lines
	localparam int          CLK_NS        = 50;            // Period of REF_CLK
	localparam int          PT_DIV        = 2;             // Clocks per pulse time
	localparam int          PULSES        = 8;             // Pulse times per machine cycle
	localparam logic [2:0]  PT_ZERO       = 3'h0;          // Pulse time zero
	localparam logic [2:0]  PT_EIGHT      = 3'h4;          // Pulse time four, eight clocks into the cycle
	localparam logic [2:0]  PT_LAST       = 3'h7;          // Last pulse time of a cycle
	localparam logic [0:0]  DIV_LAST      = 1'h1;          // Last count of the pulse divider
	localparam int          MACHINE_NS    = PT_DIV * PULSES * CLK_NS; // One machine cycle
	localparam int          MARGIN_NS     = 200;           // Safety margin on each strobe phase
	localparam int          PHASE_CYC     = (MACHINE_NS + MARGIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0]  PHASE_LAST    = 5'(PHASE_CYC - 1);
	localparam int          ERR_HOLD_NS   = 1600;          // Width of the external error pulse
	localparam int          ERR_HOLD_CYC  = (ERR_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0]  ERR_LAST      = 6'(ERR_HOLD_CYC - 1);
	localparam int          UNIT_OUT_BIT  = 5;             // Address bit that marks an output unit
	localparam logic [5:0]  UNIT_NONE     = 6'h00;         // Address lines when inactive
	localparam logic [5:0]  CHAR_ZERO     = 6'h00;         // Blank / leader character
	localparam int          CHN_IN_W      = CHAR_W + 5;    // Lines the channel synchronises
	localparam int          PER_IN_W      = UNIT_W + CHAR_W + 5; // Lines the peripheral synchronises

	// Odd parity bit for a character
	function automatic logic cch_odd_par(input logic [CHAR_W-1:0] c);
		return ~(^c);
	endfunction
endpackage

// *** hdl/cch_if.sv ***
// Link between the channel and an addressed peripheral coupler.
// Assumes both ends are clocked from the same REF_CLK tree; lines are still treated as asynchronous.
`timescale 1ns/1ps
interface cch_if;
	import cch_pkg::*;
	logic [UNIT_W-1:0] unit_address_lines;   // Channel: addressed unit, zero when idle
	logic [CHAR_W-1:0] char_out_lines;       // Channel: output character
	logic              parity_out;           // Channel: odd parity of output character
	logic              precess_flag;         // Channel: precess flag
	logic              clock_detect_flag;    // Channel: clock-detect flag
	logic              channel_state_term;   // Channel: channel-state term
	logic              halt_interlock;       // Channel: halt interlock condition
	logic              strobe_n;             // Peripheral: character strobe, active low
	logic [CHAR_W-1:0] char_in_lines;        // Peripheral: input character
	logic              parity_in;            // Peripheral: odd parity of input character
	logic              parity_inhibit_n;     // Peripheral: low suppresses parity check
	logic              end_of_record_n;      // Peripheral: low requests disconnect
	logic              ext_error_n;          // Peripheral: low reports an error

	modport chan (
		output unit_address_lines, char_out_lines, parity_out, precess_flag, clock_detect_flag,
		       channel_state_term, halt_interlock,
		input  strobe_n, char_in_lines, parity_in, parity_inhibit_n, end_of_record_n, ext_error_n
	);
	modport periph (
		input  unit_address_lines, char_out_lines, parity_out, precess_flag, clock_detect_flag,
		       channel_state_term, halt_interlock,
		output strobe_n, char_in_lines, parity_in, parity_inhibit_n, end_of_record_n, ext_error_n
	);
endinterface

// *** hdl/cch_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous lines.
// Assumes each line changes slowly compared with the clock; no bus coherence is promised.
`timescale 1ns/1ps
module cch_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,       // Sampling clock
	input  wire logic             rst,       // Synchronous reset, active high
	input  wire logic [WIDTH-1:0] async_in,  // Lines from outside the domain
	input  wire logic [WIDTH-1:0] rst_val,   // Constant level held during reset
	output logic      [WIDTH-1:0] sync_out   // Lines safe to use
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	// Next values of both stages
	always_comb begin
		meta_d = rst ? rst_val : async_in;
		sync_d = rst ? rst_val : meta_q;
	end

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		meta_q   <= meta_d;
		sync_out <= sync_d;
	end
endmodule

// *** hdl/cch_channel.sv ***
// Channel end of the character handshake: flags, single character register, errors, termination.
// Assumes the user side supplies one character at a time and drains input characters on request.
//
// What this block does
// - Acknowledge loads next character unless last
// - Last acknowledge leaves halt interlock state
// - No-leader activation sets precess until loaded
// - Leader activation clears precess, register zero
// - Strobe phases each at least one cycle
// - Peripheral may interlock strobe with flags
// - Interlocked strobe low one to seven pulses; the peripheral here holds it low at least 20 clocks
// - Strobe during pending shift sets error
// - Interlocked peripheral reports own rate errors
// - External error line sets error flag
// - Paper tape leader input disconnects channel
// - End-of-record low starts disconnect
// - Peripheral decodes address before strobing
// - Output strobe interlocked with both flags
// - Output lines start false, leader holds
// - No leader: first character loads at once
// - Odd parity generated for output characters
// - Terminate command disconnects after last acknowledge
// - Halt interlock condition exposed on link
// - Input data stable while sampled
// - Input parity checked, mismatch sets error
// - Non-parity peripheral holds inhibit low
// - Precess sets after strobe returns high
`timescale 1ns/1ps
module cch_channel
	import cch_pkg::*;
(
	input  wire logic              REF_CLK,        // 20 MHz clock
	input  wire logic              RST,            // Synchronous reset, active high
	input  wire logic              ACT,            // Activation command pulse
	input  wire logic              ACT_OUTPUT,     // Activation is for output
	input  wire logic              ACT_LEADER,     // Output starts with leader
	input  wire logic              ACT_PAPER,      // Unit is a paper tape reader
	input  wire logic [UNIT_W-1:0] ACT_UNIT,       // Unit address for the activation
	input  wire logic              STOP,           // Disconnect command pulse
	input  wire logic              TERM_OUT,       // Terminate-output command pulse
	input  wire logic              CHAR_LOAD,      // Word-load pulse for one output character
	input  wire logic [CHAR_W-1:0] CHAR_DATA,      // Output character
	input  wire logic              CHAR_LAST,      // Character is the last of the output
	input  wire logic              IN_READY,       // User can take an input character
	output logic                   CHAR_BUSY,      // Output buffer holds a character
	output logic                   IN_VALID,       // Input character pulse
	output logic      [CHAR_W-1:0] IN_DATA,        // Input character
	output logic                   ACTIVE,         // Channel connected
	output logic                   ERROR,          // Sticky error flag
	cch_if.chan                    lnk             // Link to the peripheral
);
	logic [CHN_IN_W-1:0] in_s;
	logic                strobe_low, eor_low, exterr_low, inhibit_n_s, par_in_s;
	logic [CHAR_W-1:0]   char_in_s;
	logic [0:0]          div_q, div_d;
	logic [2:0]          pt_q, pt_d;
	logic                pe, at_t0, at_t8;
	logic                active_q, active_d, outm_q, outm_d, paper_q, paper_d;
	logic [UNIT_W-1:0]   unit_q, unit_d;
	logic                w4_q, w4_d, w5_q, w5_d, w6_q, w6_d;
	logic [CHAR_W-1:0]   scr_q, scr_d, cap_q, cap_d, buf_q, buf_d, ind_q, ind_d;
	logic                par_q, par_d, last_q, last_d, bfull_q, bfull_d, blast_q, blast_d;
	logic                term_q, term_d, err_q, err_d, inv_q, inv_d;
	logic                w0_q, w0_d, halt_q, halt_d, can_shift, disc;

	cch_sync #(.WIDTH(CHN_IN_W)) u_sync (
		.clk      (REF_CLK),
		.rst      (RST),
		.async_in ({lnk.strobe_n, lnk.end_of_record_n, lnk.ext_error_n, lnk.parity_inhibit_n,
		            lnk.parity_in, lnk.char_in_lines}),
		.rst_val  ({4'hf, 1'h0, CHAR_ZERO}),
		.sync_out (in_s)
	);

	// Decoded synchronised lines
	assign strobe_low  = ~in_s[CHAR_W+4];
	assign eor_low     = ~in_s[CHAR_W+3];
	assign exterr_low  = ~in_s[CHAR_W+2];
	assign inhibit_n_s = in_s[CHAR_W+1];
	assign par_in_s    = in_s[CHAR_W];
	assign char_in_s   = in_s[CHAR_W-1:0];

	// Pulse-time divider and pulse counter
	always_comb begin
		pe    = (div_q == DIV_LAST);
		div_d = pe ? '0 : div_q + 1'h1;
		pt_d  = pe ? ((pt_q == PT_LAST) ? PT_ZERO : pt_q + 3'h1) : pt_q;
		at_t0 = pe && (pt_q == PT_ZERO);
		at_t8 = pe && (pt_q == PT_EIGHT);
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			div_q <= '0;
			pt_q  <= PT_ZERO;
		end else begin
			div_q <= div_d;
			pt_q  <= pt_d;
		end
	end

	// Handshake flags, character register and termination
	always_comb begin
		active_d = active_q;
		outm_d   = outm_q;
		paper_d  = paper_q;
		unit_d   = unit_q;
		w4_d     = w4_q;
		w5_d     = w5_q;
		w6_d     = w6_q;
		scr_d    = scr_q;
		cap_d    = cap_q;
		buf_d    = buf_q;
		ind_d    = ind_q;
		par_d    = par_q;
		last_d   = last_q;
		bfull_d  = bfull_q;
		blast_d  = blast_q;
		term_d   = term_q;
		err_d    = err_q;
		inv_d    = 1'b0;
		disc     = 1'b0;
		can_shift = outm_q ? (bfull_q && !last_q) : IN_READY;
		if (ACT) begin
			active_d = 1'b1;
			outm_d   = ACT_OUTPUT;
			paper_d  = ACT_PAPER;
			unit_d   = ACT_UNIT;
			w4_d     = 1'b0;
			w6_d     = 1'b0;
			w5_d     = ACT_OUTPUT && !ACT_LEADER;
			scr_d    = CHAR_ZERO;
			par_d    = 1'b0;
			last_d   = 1'b0;
			bfull_d  = 1'b0;
			term_d   = 1'b0;
			// Clear on activation, but an external error in the same cycle wins if the channel was already active
			err_d    = active_q && exterr_low;
		end else if (active_q) begin
			// Strobe low phase sets clock detect
			if (at_t8 && !w5_q && strobe_low) begin
				w6_d = 1'b1;
			end
			if (!outm_q && w6_q && !w5_q) begin
				cap_d = char_in_s;
			end
			if (at_t0 && !w5_q && w6_q && !strobe_low) begin
				w5_d = 1'b1;
				if (!outm_q && inhibit_n_s && (cch_odd_par(cap_q) != par_in_s)) begin
					err_d = 1'b1;
				end
				if (!outm_q && paper_q && (cap_q == CHAR_ZERO)) begin
					disc = 1'b1;
				end
			end
			if (at_t8 && w5_q && !w4_q && can_shift) begin
				w4_d = 1'b1;
			end
			if (at_t0 && w4_q) begin
				w4_d = 1'b0;
				w5_d = 1'b0;
				if (outm_q) begin
					scr_d   = buf_q;
					par_d   = cch_odd_par(buf_q);
					last_d  = blast_q;
					bfull_d = 1'b0;
				end else begin
					ind_d = cap_q;
					inv_d = 1'b1;
					cap_d = CHAR_ZERO;
				end
			end
			if (at_t0 && w5_q) begin
				w6_d = 1'b0;
			end
			if (at_t8 && w5_q && !w6_q && strobe_low) begin
				err_d = 1'b1;
			end
			if (exterr_low) begin
				err_d = 1'b1;
			end
			if (TERM_OUT) begin
				term_d = 1'b1;
			end
			// end of record, terminate after last acknowledge
			if (eor_low || STOP || (halt_q && term_q && at_t8)) begin
				disc = 1'b1;
			end
		end
		// Character load only while the registered buffer is empty, so a load in the emptying cycle is dropped
		if (CHAR_LOAD && !bfull_q) begin
			buf_d   = CHAR_DATA;
			blast_d = CHAR_LAST;
			bfull_d = 1'b1;
		end
		if (disc) begin
			active_d = 1'b0;
			unit_d   = UNIT_NONE;
			w4_d     = 1'b0;
			w5_d     = 1'b0;
			w6_d     = 1'b0;
			scr_d    = CHAR_ZERO;
			par_d    = 1'b0;
			bfull_d  = 1'b0;
		end
		w0_d   = active_d && !(outm_d && last_d);
		halt_d = w5_d && !w6_d && !w0_d;
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			active_q <= 1'b0;
			outm_q   <= 1'b0;
			paper_q  <= 1'b0;
			unit_q   <= UNIT_NONE;
			w4_q     <= 1'b0;
			w5_q     <= 1'b0;
			w6_q     <= 1'b0;
			scr_q    <= CHAR_ZERO;
			cap_q    <= CHAR_ZERO;
			buf_q    <= CHAR_ZERO;
			ind_q    <= CHAR_ZERO;
			par_q    <= 1'b0;
			last_q   <= 1'b0;
			bfull_q  <= 1'b0;
			blast_q  <= 1'b0;
			term_q   <= 1'b0;
			err_q    <= 1'b0;
			inv_q    <= 1'b0;
			w0_q     <= 1'b0;
			halt_q   <= 1'b0;
		end else begin
			active_q <= active_d;
			outm_q   <= outm_d;
			paper_q  <= paper_d;
			unit_q   <= unit_d;
			w4_q     <= w4_d;
			w5_q     <= w5_d;
			w6_q     <= w6_d;
			scr_q    <= scr_d;
			cap_q    <= cap_d;
			buf_q    <= buf_d;
			ind_q    <= ind_d;
			par_q    <= par_d;
			last_q   <= last_d;
			bfull_q  <= bfull_d;
			blast_q  <= blast_d;
			term_q   <= term_d;
			err_q    <= err_d;
			inv_q    <= inv_d;
			w0_q     <= w0_d;
			halt_q   <= halt_d;
		end
	end

	// Link and user outputs straight from flops
	assign lnk.unit_address_lines = unit_q;
	assign lnk.char_out_lines     = scr_q;
	assign lnk.parity_out         = par_q;
	assign lnk.precess_flag       = w5_q;
	assign lnk.clock_detect_flag  = w6_q;
	assign lnk.channel_state_term = w0_q;
	assign lnk.halt_interlock     = halt_q;
	assign CHAR_BUSY              = bfull_q;
	assign IN_VALID               = inv_q;
	assign IN_DATA                = ind_q;
	assign ACTIVE                 = active_q;
	assign ERROR                  = err_q;
endmodule

// *** hdl/cch_periph.sv ***
// Peripheral coupler end: address decode, interlocked strobe, data, end-of-record and error lines.
// Assumes one device clock pulse per character wanted; the channel lines are asynchronous.
`timescale 1ns/1ps
module cch_periph
	import cch_pkg::*;
(
	input  wire logic              REF_CLK,     // 20 MHz clock
	input  wire logic              RST,         // Synchronous reset, active high
	input  wire logic [UNIT_W-1:0] UNIT_ID,     // Own unit address
	input  wire logic              DEV_TICK,    // Device clock pulse, wants a character
	input  wire logic [CHAR_W-1:0] SEND_DATA,   // Character to send on input units
	input  wire logic              GEN_PARITY,  // Device generates parity
	input  wire logic              EOR_REQ,     // End-of-record request pulse
	input  wire logic              EOR_ON_HALT, // Send end of record at halt interlock
	output logic                   RECV_VALID,  // Output character taken pulse
	output logic      [CHAR_W-1:0] RECV_DATA,   // Character taken from the channel
	output logic                   RECV_PERR,   // Parity of taken character wrong
	output logic                   PENDING,     // A strobe is owed
	output logic                   HALT_SEEN,   // Halt interlock seen while addressed
	output logic                   RATE_ERR,    // Device overran its own strobe
	cch_if.periph                  lnk          // Link to the channel
);
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} cch_stb_t;

	logic [PER_IN_W-1:0] in_s;
	logic [UNIT_W-1:0]   unit_s;
	logic [CHAR_W-1:0]   cout_s;
	logic                pout_s, prec_s, cd_s, halt_s, addressed;
	cch_stb_t            st_q, st_d;
	logic [4:0]          cnt_q, cnt_d;
	logic [5:0]          ecnt_q, ecnt_d;
	logic                stb_n_q, stb_n_d, pend_q, pend_d, eor_q, eor_d;
	logic [CHAR_W-1:0]   din_q, din_d, rdat_q, rdat_d;
	logic                pin_q, pin_d, inh_q, inh_d, rv_q, rv_d, rpe_q, rpe_d;
	logic                hs_q, hs_d, rerr_q, rerr_d, eerr_q, eerr_d;

	// Channel lines resynchronised before use
	cch_sync #(.WIDTH(PER_IN_W)) u_sync (
		.clk      (REF_CLK),
		.rst      (RST),
		.async_in ({lnk.unit_address_lines, lnk.char_out_lines, lnk.parity_out, lnk.precess_flag,
		            lnk.clock_detect_flag, lnk.halt_interlock, lnk.channel_state_term}),
		.rst_val  ({UNIT_NONE, CHAR_ZERO, 5'h00}),
		.sync_out (in_s)
	);

	assign unit_s    = in_s[PER_IN_W-1 -: UNIT_W];
	assign cout_s    = in_s[CHAR_W+4:5];
	assign pout_s    = in_s[4];
	assign prec_s    = in_s[3];
	assign cd_s      = in_s[2];
	assign halt_s    = in_s[1] && prec_s && !cd_s && !in_s[0]; // Line confirmed by its three terms
	assign addressed = (unit_s == UNIT_ID) && (UNIT_ID != UNIT_NONE);

	// Strobe sequencer and side lines
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		stb_n_d = stb_n_q;
		pend_d  = pend_q;
		din_d   = din_q;
		pin_d   = pin_q;
		rdat_d  = rdat_q;
		rpe_d   = rpe_q;
		rv_d    = 1'b0;
		rerr_d  = 1'b0;
		ecnt_d  = ecnt_q;
		eerr_d  = eerr_q;
		// inhibit parity check when not generated
		inh_d   = GEN_PARITY;
		hs_d    = addressed && halt_s;
		// hold end of record while addressed
		eor_d   = (eor_q || EOR_REQ || (EOR_ON_HALT && addressed && halt_s)) && addressed;
		if (DEV_TICK) begin
			if (pend_q) begin
				rerr_d = 1'b1;
				eerr_d = 1'b1;
				ecnt_d = '0;
			end else begin
				pend_d = 1'b1;
				din_d  = SEND_DATA;
				pin_d  = GEN_PARITY ? cch_odd_par(SEND_DATA) : 1'b0;
			end
		end else if (eerr_q) begin
			ecnt_d = ecnt_q + 6'h01;
			if (ecnt_q == ERR_LAST) begin
				eerr_d = 1'b0;
			end
		end
		case (st_q)
			ST_IDLE: begin
				// strobe only with both flags clear
				if (pend_q && addressed && !prec_s && !cd_s) begin
					stb_n_d = 1'b0;
					st_d    = ST_LOW;
					cnt_d   = '0;
					if (unit_s[UNIT_OUT_BIT]) begin
						rdat_d = cout_s;
						rpe_d  = (cch_odd_par(cout_s) != pout_s);
						rv_d   = 1'b1;
					end
				end
			end
			ST_LOW: begin
				// low until detected and one cycle elapsed
				if (cnt_q != PHASE_LAST) begin
					cnt_d = cnt_q + 5'h01;
				end else if (cd_s || !addressed) begin
					stb_n_d = 1'b1;
					st_d    = ST_HIGH;
					cnt_d   = '0;
				end
			end
			ST_HIGH: begin
				// high phase at least one cycle
				if (cnt_q != PHASE_LAST) begin
					cnt_d = cnt_q + 5'h01;
				end else begin
					pend_d = 1'b0;
					st_d   = ST_IDLE;
				end
			end
			default: begin
				st_d    = ST_IDLE;
				stb_n_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			st_q    <= ST_IDLE;
			cnt_q   <= '0;
			ecnt_q  <= '0;
			stb_n_q <= 1'b1;
			pend_q  <= 1'b0;
			eor_q   <= 1'b0;
			din_q   <= CHAR_ZERO;
			pin_q   <= 1'b0;
			inh_q   <= 1'b0;
			rdat_q  <= CHAR_ZERO;
			rv_q    <= 1'b0;
			rpe_q   <= 1'b0;
			hs_q    <= 1'b0;
			rerr_q  <= 1'b0;
			eerr_q  <= 1'b0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			ecnt_q  <= ecnt_d;
			stb_n_q <= stb_n_d;
			pend_q  <= pend_d;
			eor_q   <= eor_d;
			din_q   <= din_d;
			pin_q   <= pin_d;
			inh_q   <= inh_d;
			rdat_q  <= rdat_d;
			rv_q    <= rv_d;
			rpe_q   <= rpe_d;
			hs_q    <= hs_d;
			rerr_q  <= rerr_d;
			eerr_q  <= eerr_d;
		end
	end

	// Link and user outputs straight from flops
	assign lnk.strobe_n         = stb_n_q;
	assign lnk.char_in_lines    = din_q;
	assign lnk.parity_in        = pin_q;
	assign lnk.parity_inhibit_n = inh_q;
	assign lnk.end_of_record_n  = ~eor_q;
	assign lnk.ext_error_n      = ~eerr_q;
	assign RECV_VALID           = rv_q;
	assign RECV_DATA            = rdat_q;
	assign RECV_PERR            = rpe_q;
	assign PENDING              = pend_q;
	assign HALT_SEEN            = hs_q;
	assign RATE_ERR             = rerr_q;
endmodule

// *** bench/cch_chk.sv ***
// Checker for the character link: flag order, strobe phases, parity and disconnect.
// Assumes it watches the one link where both ends are design modules.
`timescale 1ns/1ps
module cch_chk
	import cch_pkg::*;
(
	input wire logic              REF_CLK,            // Clock
	input wire logic              RST,                // Reset
	input wire logic [UNIT_W-1:0] unit_address_lines, // Addressed unit
	input wire logic [CHAR_W-1:0] char_out_lines,     // Output character
	input wire logic              parity_out,         // Output parity
	input wire logic              precess_flag,       // Precess flag
	input wire logic              clock_detect_flag,  // Clock-detect flag
	input wire logic              channel_state_term, // Channel-state term
	input wire logic              halt_interlock,     // Halt interlock
	input wire logic              strobe_n,           // Strobe
	input wire logic              end_of_record_n     // End of record
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// Link relations, one per label
	a_idle_clear: assert property (unit_address_lines == 6'h00 |->
		char_out_lines == 6'h00 && !precess_flag && !clock_detect_flag) else $error("idle link not clear");
	a_odd_parity: assert property (char_out_lines != 6'h00 |-> parity_out == ~^char_out_lines)
		else $error("output parity not odd");
	a_halt_state: assert property ($rose(halt_interlock) |->
		precess_flag && !clock_detect_flag && !channel_state_term) else $error("halt without its flags");
	a_detect_low: assert property ($rose(clock_detect_flag) |-> !strobe_n)
		else $error("detect set with strobe high");
	a_precess_high: assert property ($rose(precess_flag) && clock_detect_flag |->
		strobe_n && $past(strobe_n, 2)) else $error("precess set before strobe rose");
	a_detect_fall: assert property ($fell(clock_detect_flag) |->
		$past(precess_flag) || unit_address_lines == 6'h00) else $error("detect cleared without precess");
	a_strobe_gate: assert property ($fell(strobe_n) |-> !precess_flag && !clock_detect_flag)
		else $error("strobe while flags set");
	a_low_phase: assert property ($fell(strobe_n) |-> (!strobe_n) [*8])
		else $error("strobe low phase short");
	a_eor_drop: assert property (!end_of_record_n && unit_address_lines != 6'h00 |->
		##[1:40] unit_address_lines == 6'h00) else $error("no disconnect on end of record");

	// Main scenarios seen
	c_halt: cover property ($rose(halt_interlock));
	c_strobe: cover property ($fell(strobe_n));
	c_eor: cover property (!end_of_record_n);
endmodule

// *** bench/char_channel_handshake_test.sv ***
// Testbench joining channel and peripheral ends; scenarios drive the user sides.
// Assumes a 50 ns clock; the peripheral makes its strobe from the same clock.
`timescale 1ns/1ps
module char_channel_handshake_test;
	import cch_pkg::*;
	logic       clk, rst, act, act_out, act_lead, act_paper, stop, term, load, last, dtick, eor;
	logic       busy, in_valid, active, error, recv_valid, perr, pending, in_rdy, gen_par, rate_err, halt_seen;
	logic [5:0] act_unit, cdata, sdata, in_data, recv_data;
	int         fails, compares, n;

	cch_if cch_if_inst ();
	cch_channel cch_channel_inst (.REF_CLK(clk), .RST(rst), .ACT(act), .ACT_OUTPUT(act_out),
		.ACT_LEADER(act_lead), .ACT_PAPER(act_paper), .ACT_UNIT(act_unit), .STOP(stop), .TERM_OUT(term),
		.CHAR_LOAD(load), .CHAR_DATA(cdata), .CHAR_LAST(last), .IN_READY(in_rdy), .CHAR_BUSY(busy),
		.IN_VALID(in_valid), .IN_DATA(in_data), .ACTIVE(active), .ERROR(error), .lnk(cch_if_inst));
	cch_periph cch_periph_inst (.REF_CLK(clk), .RST(rst), .UNIT_ID(act_unit), .DEV_TICK(dtick),
		.SEND_DATA(sdata), .GEN_PARITY(gen_par), .EOR_REQ(eor), .EOR_ON_HALT(1'b0), .RECV_VALID(recv_valid),
		.RECV_DATA(recv_data), .RECV_PERR(perr), .PENDING(pending), .HALT_SEEN(halt_seen), .RATE_ERR(rate_err),
		.lnk(cch_if_inst));
	cch_chk cch_chk_inst (.REF_CLK(clk), .RST(rst), .unit_address_lines(cch_if_inst.unit_address_lines),
		.char_out_lines(cch_if_inst.char_out_lines), .parity_out(cch_if_inst.parity_out),
		.precess_flag(cch_if_inst.precess_flag), .clock_detect_flag(cch_if_inst.clock_detect_flag),
		.channel_state_term(cch_if_inst.channel_state_term), .halt_interlock(cch_if_inst.halt_interlock),
		.strobe_n(cch_if_inst.strobe_n), .end_of_record_n(cch_if_inst.end_of_record_n));

	// Verdict and end of run
	task automatic test_done();
		$display("compares %0d, fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Comparisons of characters and of flags
	task automatic chk_v(input logic [5:0] g, input logic [5:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic chk_f(input logic g, input logic e);
		chk_v({5'h00, g}, {5'h00, e});
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// Activation command with its mode
	task automatic start(input logic o, input logic l, input logic p, input logic [5:0] u);
		// Idle gap lets the far end's lines settle after a disconnect
		repeat (8) @(posedge clk);
		act <= 1'b1;
		act_out <= o;
		act_lead <= l;
		act_paper <= p;
		act_unit <= u;
		@(posedge clk);
		act <= 1'b0;
		#1;
	endtask

	task automatic disconnect();
		@(posedge clk);
		stop <= 1'b1;
		@(posedge clk);
		stop <= 1'b0;
		for (n = 0; n < 900 && active !== 1'b0; n++) tick();
	endtask

	// Output without leader: three characters, last one with terminate
	task automatic t_output();
		logic [5:0] c;
		start(1'b1, 1'b0, 1'b0, 6'h21);
		chk_f(cch_if_inst.precess_flag, 1'b1);
		for (int i = 0; i < 3; i++) begin
			c = 6'(6'h15 * (i + 1));
			for (n = 0; n < 900 && (busy | pending) !== 1'b0; n++) tick();
			@(posedge clk);
			load <= 1'b1;
			cdata <= c;
			last <= (i == 2);
			term <= (i == 2);
			dtick <= 1'b1;
			@(posedge clk);
			load <= 1'b0;
			term <= 1'b0;
			dtick <= 1'b0;
			#1;
			if (i == 0) begin
				for (n = 0; n < 900 && cch_if_inst.precess_flag !== 1'b0; n++) tick();
				chk_v(cch_if_inst.char_out_lines, c);
			end
			for (n = 0; n < 900 && recv_valid !== 1'b1; n++) tick();
			chk_v(recv_data, c);
			chk_f(perr, 1'b0);
		end
		for (n = 0; n < 900 && cch_if_inst.halt_interlock !== 1'b1; n++) tick();
		chk_f(cch_if_inst.halt_interlock, 1'b1);
		for (n = 0; n < 20 && halt_seen !== 1'b1; n++) tick();
		chk_f(halt_seen, 1'b1);
		for (n = 0; n < 900 && active !== 1'b0; n++) tick();
		chk_v(cch_if_inst.unit_address_lines, 6'h00);
	endtask

	// Output with leader: nothing presented before the first strobe
	task automatic t_leader();
		start(1'b1, 1'b1, 1'b0, 6'h22);
		chk_f(cch_if_inst.precess_flag, 1'b0);
		chk_v(cch_if_inst.char_out_lines, 6'h00);
		chk_f(cch_if_inst.parity_out, 1'b0);
		disconnect();
	endtask

	// Input of one character, ended by end of record or by paper leader (sent without parity)
	task automatic t_input(input logic p, input logic [5:0] c);
		start(1'b0, 1'b0, p, 6'h01);
		@(posedge clk);
		dtick <= 1'b1;
		sdata <= c;
		in_rdy <= p;
		gen_par <= !p;
		@(posedge clk);
		dtick <= 1'b0;
		if (!p) begin
			// User not ready: character waits with precess set
			for (n = 0; n < 900 && cch_if_inst.precess_flag !== 1'b1; n++) tick();
			repeat (40) tick();
			chk_f(cch_if_inst.precess_flag, 1'b1);
			@(posedge clk);
			in_rdy <= 1'b1;
			for (n = 0; n < 900 && in_valid !== 1'b1; n++) tick();
			chk_v(in_data, c);
			@(posedge clk);
			eor <= 1'b1;
			@(posedge clk);
			eor <= 1'b0;
		end
		for (n = 0; n < 900 && active !== 1'b0; n++) tick();
		chk_f(active, 1'b0);
		chk_f(error, 1'b0);
	endtask

	// Device overrun reported on the error line, then cleared by activation
	task automatic t_error();
		start(1'b0, 1'b0, 1'b0, 6'h02);
		@(posedge clk);
		dtick <= 1'b1;
		sdata <= 6'h07;
		repeat (3) @(posedge clk);
		dtick <= 1'b0;
		#1;
		chk_f(rate_err, 1'b1);
		for (n = 0; n < 900 && error !== 1'b1; n++) tick();
		chk_f(error, 1'b1);
		disconnect();
		repeat (60) tick();
		start(1'b0, 1'b0, 1'b0, 6'h02);
		chk_f(error, 1'b0);
		disconnect();
	endtask

	// Clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		{act, act_out, act_lead, act_paper, stop, term, load, last, dtick, eor} = '0;
		{act_unit, cdata, sdata} = '0;
		{in_rdy, gen_par} = 2'h3;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_output();
		t_leader();
		t_input(1'b0, 6'h2b);
		t_input(1'b1, 6'h00);
		t_error();
		test_done();
	end

	// Watchdog
	initial begin
		#1000000;
		fails++;
		test_done();
	end
endmodule
